// ===== hw/fpec_pkg.sv
// Package for the flash program/erase control register block.
// Assumes a 32-bit AXI4-Lite register bus on a single 25 MHz clock.
package fpec_pkg;
  // Register word offsets. The low byte of each printed address is kept as the index.
  localparam logic [7:0] FPEC_IDX_MODE = 8'h20;
  localparam logic [7:0] FPEC_IDX_STAT = 8'h21;
  localparam logic [7:0] FPEC_IDX_PWR = 8'h22;
  localparam logic [7:0] FPEC_IDX_BLK = 8'h23;
  localparam logic [7:0] FPEC_IDX_ENA = 8'h2b;
  localparam int FPEC_ADDR_W = 12;
  // Mode control field positions.
  localparam int FPEC_B_RSV = 7;
  localparam int FPEC_B_SWE = 6;
  localparam int FPEC_B_CSU = 5;
  localparam int FPEC_B_BSU = 4;
  localparam int FPEC_B_CCHK = 3;
  localparam int FPEC_B_BCHK = 2;
  localparam int FPEC_B_CRUN = 1;
  localparam int FPEC_B_BRUN = 0;
  // Single-bit fields of the other registers.
  localparam int FPEC_B_TOP = 7;
  localparam int FPEC_NBLK = 5;
  localparam logic [7:0] FPEC_RST = 8'h00;
  localparam logic [1:0] FPEC_RESP_OKAY = 2'b00;
  localparam logic [1:0] FPEC_RESP_SLVERR = 2'b10;
  // Block address bounds; the last block ends at a size-dependent limit.
  localparam logic [15:0] FPEC_BLK_SIZE = 16'h0400;
  localparam logic [15:0] FPEC_TOP_SMALL = 16'h3fff;
  localparam logic [15:0] FPEC_TOP_LARGE = 16'h7fff;
  typedef enum logic [2:0] {
    FPEC_M_READ, FPEC_M_BURN_SETUP, FPEC_M_BURN, FPEC_M_BURN_CHK,
    FPEC_M_CLR_SETUP, FPEC_M_CLR, FPEC_M_CLR_CHK, FPEC_M_IDLE_EN
  } fpec_mode_type;
endpackage : fpec_pkg

// ===== hw/fpec_top.sv
// Flash program/erase control registers behind an AXI4-Lite slave.
// Assumes the array controller reports faults and the chip reports subactive mode.
`timescale 1ns/10ps
`default_nettype none
// Notes on behaviour
// R1: Mode control bit 7 reads zero and ignores writes.
// R2: Without write enable, no other mode or block select bit can be set.
// R3: Erase setup bit enters and cancels erase setup state.
// R4: Program setup bit enters and cancels program setup state.
// R5: Erase mode needs write enable and erase setup when run bit set.
// R6: Program mode needs write enable and program setup when run bit set.
// R7: Erase-verify bit enters and cancels erase-verify mode.
// R8: Program-verify bit enters and cancels program-verify mode.
// R9: Software sets one mode control bit per write.
// R10: Software clears mode bits before reading flash as ROM.
// R11: Error flag sets on program/erase fault, else reads zero.
// R12: Status register is read-only; low seven bits read zero.
// R13: Block select is held zero while write enable is zero.
// R14: More than one block select bit set clears all of them.
// R15: Only the selected block may be erased; others are protected.
// R16: Bits 0-3 select 1-Kbyte blocks; bit 4 selects the remainder.
// R17: Software erases the whole array block by block.
// R18: In subactive mode flash powers down unless inhibit bit is set.
// R19: Control registers are accessible only while unlock bit is set.
// R20: Reserved low bits of status, power, enable registers read zero.
// R21: Registers are eight bits wide, one per word.
// R22: Registers at offsets 0x20..0x23 and 0x2b.
// R23: Locked registers read zero and ignore writes.
// R24: All registers reset to zero.
module fpec_top #(
  parameter bit LARGE_ARRAY = 1'b1
) (
  input wire logic aclk, // System clock.
  input wire logic aresetn, // Synchronous reset, active low.
  input wire logic [fpec_pkg::FPEC_ADDR_W-1:0] s_axi_awaddr, // Write address.
  input wire logic s_axi_awvalid, // Write address valid.
  output logic s_axi_awready, // Write address ready.
  input wire logic [31:0] s_axi_wdata, // Write data.
  input wire logic [3:0] s_axi_wstrb, // Write strobes.
  input wire logic s_axi_wvalid, // Write data valid.
  output logic s_axi_wready, // Write data ready.
  output logic [1:0] s_axi_bresp, // Write response.
  output logic s_axi_bvalid, // Write response valid.
  input wire logic s_axi_bready, // Write response ready.
  input wire logic [fpec_pkg::FPEC_ADDR_W-1:0] s_axi_araddr, // Read address.
  input wire logic s_axi_arvalid, // Read address valid.
  output logic s_axi_arready, // Read address ready.
  output logic [31:0] s_axi_rdata, // Read data.
  output logic [1:0] s_axi_rresp, // Read response.
  output logic s_axi_rvalid, // Read data valid.
  input wire logic s_axi_rready, // Read data ready.
  input wire logic fault_evt, // Array fault seen during program or erase, pulse.
  input wire logic subactive, // Chip is in subactive mode, level.
  input wire logic [15:0] array_addr, // Address the array is about to erase.
  output fpec_pkg::fpec_mode_type flash_mode, // Current array mode.
  output logic [4:0] erase_sel, // Selected erase block, one-hot or zero.
  output logic erase_allow, // Erase permitted at array_addr.
  output logic flash_powerdown // Array in power-down mode.
);
  import fpec_pkg::*;

  // ----------------------------------------------------------------
  // Register state
  // ----------------------------------------------------------------
  logic [7:0] mode_q, mode_d;
  logic [4:0] blk_q, blk_d;
  logic fault_q, fault_d;
  logic pinh_q, pinh_d;
  logic unlock_q, unlock_d;
  logic aw_q, aw_d, w_q, w_d, bv_q, bv_d, rv_q, rv_d;
  logic [7:0] awa_q, awa_d, wd_q, wd_d;
  logic wst_q, wst_d;
  logic [1:0] br_q, br_d, rr_q, rr_d;
  logic [31:0] rd_q, rd_d;
  fpec_mode_type fm_q, fm_d;
  logic [4:0] es_q, es_d;
  logic pd_q, pd_d;

  // Word index of a byte address; registers sit one per word.
  function automatic logic [7:0] widx(input logic [FPEC_ADDR_W-1:0] a);
    widx = a[9:2];
  endfunction : widx

  function automatic logic is_ctrl(input logic [7:0] i); // R22
    is_ctrl = (i == FPEC_IDX_MODE) || (i == FPEC_IDX_STAT) ||
              (i == FPEC_IDX_PWR) || (i == FPEC_IDX_BLK);
  endfunction : is_ctrl

  function automatic logic onehot_many(input logic [4:0] v);
    onehot_many = (v & (v - 5'h01)) != 5'h00;
  endfunction : onehot_many

  logic do_wr, do_rd;
  assign s_axi_awready = !aw_q && !bv_q;
  assign s_axi_wready = !w_q && !bv_q;
  assign s_axi_arready = !rv_q;
  assign do_wr = aw_q && w_q && !bv_q;
  assign do_rd = s_axi_arvalid && !rv_q;

  // ----------------------------------------------------------------
  // Bus and register next state
  // ----------------------------------------------------------------
  always_comb
  begin
    logic [7:0] nm;
    logic [4:0] nb;
    logic acc_ok;
    nm = mode_q;
    nb = blk_q;
    acc_ok = 1'b0;
    aw_d = aw_q;
    w_d = w_q;
    bv_d = bv_q;
    rv_d = rv_q;
    awa_d = awa_q;
    wd_d = wd_q;
    wst_d = wst_q;
    br_d = br_q;
    rr_d = rr_q;
    rd_d = rd_q;
    pinh_d = pinh_q;
    unlock_d = unlock_q;
    if (s_axi_awvalid && s_axi_awready)
    begin
      aw_d = 1'b1;
      awa_d = widx(s_axi_awaddr);
    end
    if (s_axi_wvalid && s_axi_wready)
    begin
      w_d = 1'b1;
      wd_d = s_axi_wdata[7:0];
      wst_d = s_axi_wstrb[0];
    end
    if (do_wr)
    begin
      aw_d = 1'b0;
      w_d = 1'b0;
      bv_d = 1'b1;
      br_d = FPEC_RESP_OKAY;
      acc_ok = unlock_q || !is_ctrl(awa_q); // R19 R23
      if (!(is_ctrl(awa_q) || awa_q == FPEC_IDX_ENA))
        br_d = FPEC_RESP_SLVERR;
      else if (wst_q && acc_ok) // R21
      begin
        case (awa_q)
          FPEC_IDX_MODE:
          begin
            nm = {1'b0, wd_q[6:0]}; // R1
            if (!wd_q[FPEC_B_SWE])
              nm = FPEC_RST; // R2
            else if (!mode_q[FPEC_B_SWE])
              nm = FPEC_RST | (8'h01 << FPEC_B_SWE); // R2 R9
          end
          FPEC_IDX_BLK: nb = mode_q[FPEC_B_SWE] ? wd_q[4:0] : 5'h00; // R2
          FPEC_IDX_PWR: pinh_d = wd_q[FPEC_B_TOP];
          FPEC_IDX_ENA: unlock_d = wd_q[FPEC_B_TOP];
          default: ; // Status is read-only. R12
        endcase
      end
    end
    if (bv_q && s_axi_bready)
      bv_d = 1'b0;
    if (do_rd)
    begin
      rv_d = 1'b1;
      rr_d = FPEC_RESP_OKAY;
      rd_d = 32'h00000000;
      case (widx(s_axi_araddr))
        FPEC_IDX_MODE: rd_d[7:0] = unlock_q ? mode_q : FPEC_RST; // R1 R23
        FPEC_IDX_STAT: rd_d[FPEC_B_TOP] = unlock_q && fault_q; // R12 R20
        FPEC_IDX_PWR: rd_d[FPEC_B_TOP] = unlock_q && pinh_q; // R20
        FPEC_IDX_BLK: rd_d[4:0] = unlock_q ? blk_q : 5'h00; // R23
        FPEC_IDX_ENA: rd_d[FPEC_B_TOP] = unlock_q; // R20
        default: rr_d = FPEC_RESP_SLVERR;
      endcase
    end
    if (rv_q && s_axi_rready)
      rv_d = 1'b0;
    if (!nm[FPEC_B_SWE])
      nb = 5'h00; // R13
    if (onehot_many(nb))
      nb = 5'h00; // R14
    mode_d = nm;
    blk_d = nb;
  end

  // ----------------------------------------------------------------
  // Array mode, fault flag and power
  // ----------------------------------------------------------------
  always_comb
  begin
    fault_d = fault_q;
    if (fault_evt && (fm_q == FPEC_M_BURN || fm_q == FPEC_M_CLR))
      fault_d = 1'b1; // R11
    fm_d = FPEC_M_READ;
    if (mode_q[FPEC_B_SWE])
    begin
      fm_d = FPEC_M_IDLE_EN;
      if (mode_q[FPEC_B_CSU])
        fm_d = (mode_q[FPEC_B_CRUN] && !fault_q) ? FPEC_M_CLR : FPEC_M_CLR_SETUP; // R3 R5
      else if (mode_q[FPEC_B_BSU])
        fm_d = (mode_q[FPEC_B_BRUN] && !fault_q) ? FPEC_M_BURN : FPEC_M_BURN_SETUP; // R4 R6
      else if (mode_q[FPEC_B_CCHK])
        fm_d = FPEC_M_CLR_CHK; // R7
      else if (mode_q[FPEC_B_BCHK])
        fm_d = FPEC_M_BURN_CHK; // R8
    end
    es_d = blk_q; // R15
    pd_d = subactive && !pinh_q; // R18
  end

  // Erase window decode; the last block ends where the array ends.
  logic [15:0] top_addr;
  logic [2:0] blk_of;
  assign top_addr = LARGE_ARRAY ? FPEC_TOP_LARGE : FPEC_TOP_SMALL;
  always_comb
  begin
    blk_of = 3'd4;
    if (array_addr < (FPEC_BLK_SIZE << 2))
      blk_of = array_addr[12:10]; // R16
  end
  assign erase_allow = (fm_q == FPEC_M_CLR) && (array_addr <= top_addr) &&
                       es_q[blk_of]; // R15 R16

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      mode_q <= FPEC_RST; // R24
      blk_q <= 5'h00;
      fault_q <= 1'b0;
      pinh_q <= 1'b0;
      unlock_q <= 1'b0;
      aw_q <= 1'b0;
      w_q <= 1'b0;
      bv_q <= 1'b0;
      rv_q <= 1'b0;
      awa_q <= 8'h00;
      wd_q <= 8'h00;
      wst_q <= 1'b0;
      br_q <= 2'b00;
      rr_q <= 2'b00;
      rd_q <= 32'h00000000;
      fm_q <= FPEC_M_READ;
      es_q <= 5'h00;
      pd_q <= 1'b0;
    end
    else
    begin
      mode_q <= mode_d;
      blk_q <= blk_d;
      fault_q <= fault_d;
      pinh_q <= pinh_d;
      unlock_q <= unlock_d;
      aw_q <= aw_d;
      w_q <= w_d;
      bv_q <= bv_d;
      rv_q <= rv_d;
      awa_q <= awa_d;
      wd_q <= wd_d;
      wst_q <= wst_d;
      br_q <= br_d;
      rr_q <= rr_d;
      rd_q <= rd_d;
      fm_q <= fm_d;
      es_q <= es_d;
      pd_q <= pd_d;
    end
  end

  assign s_axi_bvalid = bv_q;
  assign s_axi_bresp = br_q;
  assign s_axi_rvalid = rv_q;
  assign s_axi_rresp = rr_q;
  assign s_axi_rdata = rd_q;
  assign flash_mode = fm_q;
  assign erase_sel = es_q;
  assign flash_powerdown = pd_q;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  a_top_bit_zero: assert property (@(posedge aclk) disable iff (!aresetn)
    !mode_q[FPEC_B_RSV]) else $error("mode top bit set"); // R1
  a_swe_gates_bits: assert property (@(posedge aclk) disable iff (!aresetn)
    !mode_q[FPEC_B_SWE] |-> (mode_q == FPEC_RST && blk_q == 5'h00))
    else $error("bits set without write enable"); // R2
  a_erase_mode_cause: assert property (@(posedge aclk) disable iff (!aresetn)
    fm_q == FPEC_M_CLR |-> $past(mode_q[FPEC_B_SWE] && mode_q[FPEC_B_CSU] &&
    mode_q[FPEC_B_CRUN])) else $error("erase mode without setup"); // R5 R3
  a_prog_mode_cause: assert property (@(posedge aclk) disable iff (!aresetn)
    fm_q == FPEC_M_BURN |-> $past(mode_q[FPEC_B_SWE] && mode_q[FPEC_B_BSU] &&
    mode_q[FPEC_B_BRUN])) else $error("program mode without setup"); // R6 R4
  a_verify_modes: assert property (@(posedge aclk) disable iff (!aresetn)
    $past(mode_q[FPEC_B_SWE] && mode_q[7:4] == 4'h4 && mode_q[FPEC_B_CCHK])
    |-> fm_q == FPEC_M_CLR_CHK) else $error("erase verify missed"); // R7
  a_pverify_mode: assert property (@(posedge aclk) disable iff (!aresetn)
    $past(mode_q[7:3] == 5'h08 && mode_q[FPEC_B_BCHK]) |-> fm_q == FPEC_M_BURN_CHK)
    else $error("program verify missed"); // R8
  a_fault_sticky: assert property (@(posedge aclk) disable iff (!aresetn)
    fault_evt && (fm_q == FPEC_M_CLR || fm_q == FPEC_M_BURN) |=> fault_q [*2])
    else $error("fault lost"); // R11
  a_blk_onehot: assert property (@(posedge aclk) disable iff (!aresetn)
    !onehot_many(blk_q)) else $error("several blocks selected"); // R14
  a_power_down: assert property (@(posedge aclk) disable iff (!aresetn)
    $rose(subactive) && !pinh_q ##1 !pinh_q |-> flash_powerdown)
    else $error("power down missed"); // R18
  a_locked_read: assert property (@(posedge aclk) disable iff (!aresetn)
    do_rd && !unlock_q && is_ctrl(widx(s_axi_araddr)) |=> s_axi_rdata == 32'h0)
    else $error("locked register readable"); // R19 R23
  a_lock_write: assert property (@(posedge aclk) disable iff (!aresetn) // R23
    do_wr && !unlock_q && is_ctrl(awa_q) |=> mode_q == $past(mode_q) && blk_q == $past(blk_q))
    else $error("locked register written");
  a_stat_low_zero: assert property (@(posedge aclk) disable iff (!aresetn) // R12 R20
    do_rd && widx(s_axi_araddr) == FPEC_IDX_STAT |=> s_axi_rdata[6:0] == 7'h00)
    else $error("status low bits set");
  a_pwr_low_zero: assert property (@(posedge aclk) disable iff (!aresetn) // R20
    do_rd && widx(s_axi_araddr) == FPEC_IDX_PWR |=> s_axi_rdata[6:0] == 7'h00)
    else $error("power low bits set");
  a_ena_readback: assert property (@(posedge aclk) disable iff (!aresetn) // R19 R20
    do_rd && widx(s_axi_araddr) == FPEC_IDX_ENA |=> s_axi_rdata == {24'h0, $past(unlock_q), 7'h00})
    else $error("enable read wrong");
  a_fault_quiet: assert property (@(posedge aclk) disable iff (!aresetn) // R11
    !fault_q && !fault_evt |=> !fault_q) else $error("fault without event");
  a_fault_blocks: assert property (@(posedge aclk) disable iff (!aresetn) // R11
    fault_q |=> fm_q != FPEC_M_CLR && fm_q != FPEC_M_BURN)
    else $error("operation after fault");
  a_read_when_off: assert property (@(posedge aclk) disable iff (!aresetn) // R2
    !mode_q[FPEC_B_SWE] |=> fm_q == FPEC_M_READ) else $error("mode without enable");
  a_erase_setup: assert property (@(posedge aclk) disable iff (!aresetn) // R3
    mode_q[FPEC_B_SWE] && mode_q[FPEC_B_CSU] && !mode_q[FPEC_B_CRUN]
    |=> fm_q == FPEC_M_CLR_SETUP) else $error("erase setup missed");
  a_prog_setup: assert property (@(posedge aclk) disable iff (!aresetn) // R4
    mode_q[FPEC_B_SWE] && !mode_q[FPEC_B_CSU] && mode_q[FPEC_B_BSU] && !mode_q[FPEC_B_BRUN]
    |=> fm_q == FPEC_M_BURN_SETUP) else $error("program setup missed");
  a_power_up: assert property (@(posedge aclk) disable iff (!aresetn) // R18
    !subactive |=> !flash_powerdown) else $error("power down outside subactive");
  a_sel_follows: assert property (@(posedge aclk) disable iff (!aresetn) // R15
    erase_sel == $past(blk_q)) else $error("erase select stale");
  a_allow_needs_clr: assert property (@(posedge aclk) disable iff (!aresetn) // R15
    erase_allow |-> flash_mode == FPEC_M_CLR && erase_sel != 5'h00)
    else $error("erase allowed outside erase mode");

  // ----------------------------------------------------------------
  // Bus answer checks
  // ----------------------------------------------------------------
  // Both halves held means the response must show on the next edge.
  sequence s_write_taken;
    do_wr;
  endsequence
  sequence s_write_answer;
    s_axi_bvalid;
  endsequence
  sequence s_read_taken;
    do_rd;
  endsequence
  sequence s_read_answer;
    s_axi_rvalid;
  endsequence
  property p_write_answer;
    @(posedge aclk) disable iff (!aresetn) s_write_taken |=> s_write_answer;
  endproperty
  property p_read_answer;
    @(posedge aclk) disable iff (!aresetn) s_read_taken |=> s_read_answer;
  endproperty
  a_write_answer: assert property (p_write_answer) else $error("write not answered"); // R21
  a_read_answer: assert property (p_read_answer) else $error("read not answered"); // R21
endmodule : fpec_top
`default_nettype wire

// ===== test/fpec_top_tb_top.sv
// Self-checking bench for the flash program/erase control register block.
// Assumes the block is the only AXI4-Lite slave and the bench is its only master.
`timescale 1ns/10ps
`default_nettype none
`define CHK(nm, e, s) begin total_checks++; if ((s) !== (e)) begin miscompares++; \
  $display("unexpected %s expected %h seen %h", nm, e, s); end end
module fpec_top_tb_top;
  import fpec_pkg::*;
  // ---------------------------------------------
  // Signals
  // ---------------------------------------------
  logic aclk = 1'b0, aresetn = 1'b0;
  logic [11:0] s_axi_awaddr = 12'h0, s_axi_araddr = 12'h0;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_arvalid = 1'b0;
  logic [31:0] s_axi_wdata = 32'h0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [31:0] s_axi_rdata;
  logic fault_evt = 1'b0, subactive = 1'b0, erase_allow, flash_powerdown;
  logic [15:0] array_addr = 16'h0, seed = 16'd36735;
  fpec_mode_type flash_mode;
  logic [4:0] erase_sel;
  logic [34:0] exp_q[$];
  logic [34:0] e;
  int miscompares = 0, total_checks = 0;
  always #20 aclk = ~aclk;
  fpec_top #(.LARGE_ARRAY(1'b1)) i_dut (.aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
    .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(1'b1), .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
    .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(1'b1), .fault_evt(fault_evt),
    .subactive(subactive), .array_addr(array_addr), .flash_mode(flash_mode),
    .erase_sel(erase_sel), .erase_allow(erase_allow), .flash_powerdown(flash_powerdown));
  // ---------------------------------------------
  // Helpers
  // ---------------------------------------------
  function automatic logic [11:0] adr(input logic [7:0] idx);
    return {2'b00, idx, 2'b00};
  endfunction : adr
  function automatic logic [15:0] lfsr(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction : lfsr
  task automatic complete_run();
    $display("checks %0d mismatches %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : complete_run
  // Ready is sampled on the falling edge, where it has settled; the handshake then
  // happens at the next rising edge, at which the valid is released.
  task automatic wr(input logic [11:0] a, input logic [7:0] d, input logic [1:0] r);
    logic aw_done, w_done;
    aw_done = 1'b0;
    w_done = 1'b0;
    @(posedge aclk);
    exp_q.push_back({1'b0, r, 32'h0});
    s_axi_awaddr <= a;
    s_axi_wdata <= {24'h0, d};
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    while (!(aw_done && w_done))
    begin
      @(negedge aclk);
      if (s_axi_awready) aw_done = 1'b1;
      if (s_axi_wready) w_done = 1'b1;
      @(posedge aclk);
      if (aw_done) s_axi_awvalid <= 1'b0;
      if (w_done) s_axi_wvalid <= 1'b0;
    end
    do @(negedge aclk); while (s_axi_bvalid !== 1'b1);
  endtask : wr
  task automatic rd(input logic [11:0] a, input logic [7:0] d, input logic [1:0] r);
    @(posedge aclk);
    exp_q.push_back({r == FPEC_RESP_OKAY, r, 24'h0, d});
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    do @(negedge aclk); while (s_axi_arready !== 1'b1);
    @(posedge aclk);
    s_axi_arvalid <= 1'b0;
    do @(negedge aclk); while (s_axi_rvalid !== 1'b1);
  endtask : rd
  task automatic mstep(input logic [7:0] d, input fpec_mode_type m);
    wr(adr(FPEC_IDX_MODE), d, FPEC_RESP_OKAY);
    repeat (2) @(negedge aclk);
    `CHK("flash_mode", m, flash_mode)
  endtask : mstep
  // ---------------------------------------------
  // Response monitor
  // ---------------------------------------------
  always @(negedge aclk)
  begin
    if (s_axi_bvalid === 1'b1 || s_axi_rvalid === 1'b1)
    begin
      if (exp_q.size() == 0)
        miscompares++;
      e = (exp_q.size() > 0) ? exp_q.pop_front() : 35'h0;
      if (s_axi_bvalid === 1'b1)
        `CHK("bresp", e[33:32], s_axi_bresp)
      else
      begin
        `CHK("rresp", e[33:32], s_axi_rresp)
        if (e[34]) `CHK("rdata", e[31:0], s_axi_rdata)
      end
    end
  end
  initial
  begin
    repeat (20000) @(posedge aclk);
    miscompares++;
    complete_run();
  end
  // ---------------------------------------------
  // Scenarios
  // ---------------------------------------------
  initial
  begin
    repeat (16) @(posedge aclk);
    aresetn <= 1'b1;
    rd(adr(FPEC_IDX_ENA), 8'h00, FPEC_RESP_OKAY);
    wr(adr(FPEC_IDX_PWR), 8'h80, FPEC_RESP_OKAY);
    wr(adr(FPEC_IDX_ENA), 8'hff, FPEC_RESP_OKAY);
    rd(adr(FPEC_IDX_ENA), 8'h80, FPEC_RESP_OKAY);
    rd(adr(FPEC_IDX_PWR), 8'h00, FPEC_RESP_OKAY);
    rd(adr(FPEC_IDX_MODE), 8'h00, FPEC_RESP_OKAY);
    rd(adr(FPEC_IDX_STAT), 8'h00, FPEC_RESP_OKAY);
    rd(12'h090, 8'h00, FPEC_RESP_SLVERR);
    wr(12'h0a8, 8'hff, FPEC_RESP_SLVERR);
    wr(adr(FPEC_IDX_BLK), 8'h01, FPEC_RESP_OKAY);
    rd(adr(FPEC_IDX_BLK), 8'h00, FPEC_RESP_OKAY);
    wr(adr(FPEC_IDX_MODE), 8'hff, FPEC_RESP_OKAY);
    rd(adr(FPEC_IDX_MODE), 8'h40, FPEC_RESP_OKAY);
    wr(adr(FPEC_IDX_BLK), 8'h03, FPEC_RESP_OKAY);
    rd(adr(FPEC_IDX_BLK), 8'h00, FPEC_RESP_OKAY);
    wr(adr(FPEC_IDX_BLK), 8'h10, FPEC_RESP_OKAY);
    rd(adr(FPEC_IDX_BLK), 8'h10, FPEC_RESP_OKAY);
    mstep(8'h60, FPEC_M_CLR_SETUP);
    mstep(8'h62, FPEC_M_CLR);
    `CHK("erase_sel", 5'h10, erase_sel)
    for (int i = 0; i < 3; i++)
    begin
      @(posedge aclk);
      array_addr <= (i == 0) ? 16'h1000 : (i == 1) ? FPEC_TOP_LARGE : 16'h0fff;
      @(negedge aclk);
      `CHK("erase_allow", (i < 2), erase_allow)
    end
    mstep(8'h60, FPEC_M_CLR_SETUP);
    mstep(8'h40, FPEC_M_IDLE_EN);
    wr(adr(FPEC_IDX_MODE), 8'h42, FPEC_RESP_OKAY);
    repeat (2) @(negedge aclk);
    `CHK("erase_entered", 1'b0, flash_mode == FPEC_M_CLR)
    mstep(8'h40, FPEC_M_IDLE_EN);
    mstep(8'h48, FPEC_M_CLR_CHK);
    mstep(8'h40, FPEC_M_IDLE_EN);
    mstep(8'h44, FPEC_M_BURN_CHK);
    mstep(8'h40, FPEC_M_IDLE_EN);
    mstep(8'h50, FPEC_M_BURN_SETUP);
    mstep(8'h51, FPEC_M_BURN);
    rd(adr(FPEC_IDX_STAT), 8'h00, FPEC_RESP_OKAY);
    @(posedge aclk);
    fault_evt <= 1'b1;
    @(posedge aclk);
    fault_evt <= 1'b0;
    rd(adr(FPEC_IDX_STAT), 8'h80, FPEC_RESP_OKAY);
    wr(adr(FPEC_IDX_STAT), 8'hff, FPEC_RESP_OKAY);
    rd(adr(FPEC_IDX_STAT), 8'h80, FPEC_RESP_OKAY);
    mstep(8'h00, FPEC_M_READ);
    rd(adr(FPEC_IDX_BLK), 8'h00, FPEC_RESP_OKAY);
    @(posedge aclk);
    subactive <= 1'b1;
    for (int i = 0; i < 6; i++)
    begin
      seed = lfsr(seed);
      wr(adr(FPEC_IDX_PWR), seed[7:0], FPEC_RESP_OKAY);
      rd(adr(FPEC_IDX_PWR), seed[7:0] & 8'h80, FPEC_RESP_OKAY);
      repeat (2) @(negedge aclk);
      `CHK("flash_powerdown", ~seed[7], flash_powerdown)
    end
    wr(adr(FPEC_IDX_ENA), 8'h00, FPEC_RESP_OKAY);
    rd(adr(FPEC_IDX_STAT), 8'h00, FPEC_RESP_OKAY);
    wr(adr(FPEC_IDX_MODE), 8'h40, FPEC_RESP_OKAY);
    wr(adr(FPEC_IDX_ENA), 8'h80, FPEC_RESP_OKAY);
    rd(adr(FPEC_IDX_MODE), 8'h00, FPEC_RESP_OKAY);
    rd(adr(FPEC_IDX_STAT), 8'h80, FPEC_RESP_OKAY);
    repeat (4) @(posedge aclk);
    complete_run();
  end
endmodule : fpec_top_tb_top
`undef CHK
`default_nettype wire
